// ---- hdl/card_detect_zv_select.sv ----
// socket-side logic: card recognition, power switch link, zoomed video
`timescale 1ns/1ps
// Functional notes
// - interrogate pins on insertion into unpowered socket
// - both grounded 5V key: 5, 3.3, X.X
// - sense two grounded, one open: X.X only
// - detect two tied sense one: 3.3/X/Y
// - detect one tied sense two: X and Y
// - tie, sense two open: Y.Y only
// - power switch via clock, data, latch
// - serial clock pin input after reset
// - clock source bit drives clock out
// - video enable floats address lines 25..4
// - address lines 3..0 stay operational
// - two select outputs, one status output
// - select low while socket is source
// - both enabled, priority clear: socket 0
// - both enabled, priority set: socket 1
// - status high when any socket enabled
module card_detect_zv_select
	import card_socket_pkg::*;
#(
	parameter int SETTLE = card_socket_pkg::SETTLE_CYCLES,
	parameter int SER_DIV = card_socket_pkg::SER_DIV_HALF,
	parameter int WORD_W = card_socket_pkg::PS_WORD_W
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// configuration access
	input wire logic cfgFunc,
	input wire logic [7:0] cfgAddr,
	input wire logic cfgWr,
	input wire logic cfgRd,
	input wire logic [3:0] cfgByteEn,
	input wire logic [31:0] cfgWdata,
	output logic [31:0] cfgRdata,
	output logic cfgAck,
	// socket detect and sense pins
	input wire card_socket_pkg::card_pins_t [NUM_SOCKETS-1:0] cardPins,
	input wire logic [NUM_SOCKETS-1:0] socketPowered,
	output logic [NUM_SOCKETS-1:0][1:0] vsOut,
	output logic [NUM_SOCKETS-1:0][1:0] vsOeN,
	output card_socket_pkg::card_info_t [NUM_SOCKETS-1:0] cardInfo,
	output logic [NUM_SOCKETS-1:0] infoDone,
	// card address line enables
	input wire logic [NUM_SOCKETS-1:0][ADDR_W-1:0] addrOeReqN,
	output logic [NUM_SOCKETS-1:0][ADDR_W-1:0] cardAddrOeN,
	// power switch serial interface
	input wire logic serClkIn,
	output logic serClkOut,
	output logic serClkOeN,
	output logic serData,
	output logic serLatch,
	// zoomed video selects
	output logic videoSource0SelectN,
	output logic videoSource1SelectN,
	output logic videoActiveStatus
);
	import card_socket_pkg::*;

	localparam int CC_LANE = int'(CARD_CTRL_OFS[1:0]);
	localparam logic [ADDR_W-1:0] ADDR_FLOAT_MASK =
		{ADDR_W{1'b1}} << VIDEO_LOW_ADDR;

	logic [31:0] sysCtrl_q;
	logic [NUM_SOCKETS-1:0][7:0] cardCtrl_q;
	logic sysHit, cardHit;
	logic [NUM_SOCKETS-1:0] videoEn;
	logic videoPrio;
	logic clkSrcSel;

	// --- configuration registers ---

	assign sysHit = (cfgAddr[7:2] == SYS_CTRL_OFS[7:2]);
	assign cardHit = (cfgAddr[7:2] == CARD_CTRL_OFS[7:2]);

	// system control is shared by both functions
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sysCtrl_q <= SYS_CTRL_RST;
		end else if (cfgWr && sysHit) begin
			for (int b = 0; b < 4; b++) begin
				if (cfgByteEn[b]) sysCtrl_q[8*b +: 8] <= cfgWdata[8*b +: 8];
			end
		end
	end

	// card control: one byte per socket function
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cardCtrl_q <= {NUM_SOCKETS{CARD_CTRL_RST}};
		end else if (cfgWr && cardHit && cfgByteEn[CC_LANE]) begin
			cardCtrl_q[cfgFunc] <= cfgWdata[8*CC_LANE +: 8];
		end
	end

	// reads answer one cycle later; unmapped dwords read zero
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfgRdata <= 32'h00000000;
			cfgAck <= 1'b0;
		end else begin
			cfgAck <= cfgRd || cfgWr;
			if (cfgRd) begin
				if (sysHit) begin
					cfgRdata <= sysCtrl_q;
				end else if (cardHit) begin
					cfgRdata <= 32'(cardCtrl_q[cfgFunc]) << (8 * CC_LANE);
				end else begin
					cfgRdata <= 32'h00000000;
				end
			end
		end
	end

	// --- card recognition, one engine per socket ---

	for (genvar s = 0; s < NUM_SOCKETS; s++) begin : g_sock
		card_interrogate #(
			.SETTLE(SETTLE)
		) u_iq (
			.clock(clock),
			.rstn(rstn),
			.pins(cardPins[s]),
			.socketPowered(socketPowered[s]),
			.vsOeN(vsOeN[s]),
			.info(cardInfo[s]),
			.infoDone(infoDone[s])
		);
		// sense pins are only ever pulled low
		assign vsOut[s] = 2'b00;
		assign videoEn[s] = cardCtrl_q[s][VIDEO_ENABLE_BIT];

		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				cardAddrOeN[s] <= '1;
			end else begin
				cardAddrOeN[s] <= addrOeReqN[s] |
					(ADDR_FLOAT_MASK & {ADDR_W{videoEn[s]}});
			end
		end
	end

	// --- power switch serial interface ---

	// pick the lowest-risk supply the card reports
	function automatic logic [1:0] vccFor(card_info_t i);
		logic [1:0] v;
		v = VCC_OFF;
		if (!i.valid) v = VCC_OFF;
		else if (i.v33) v = VCC_3V3;
		else if (i.v5) v = VCC_5V;
		else if (i.vX) v = VCC_XV;
		return v;
	endfunction

	logic [WORD_W-1:0] cmdWord;
	logic [WORD_W-1:0] sentWord_q, shWord_q;
	logic [7:0] bitCnt_q;
	sh_state_t sh_q;
	logic [15:0] divCnt_q;
	logic clkOut_q, extPrev_q;
	logic tick;

	assign cmdWord = WORD_W'({vccFor(cardInfo[1]), VPP_OFF,
		vccFor(cardInfo[0]), VPP_OFF});
	assign clkSrcSel = sysCtrl_q[SYS_CLK_SRC_BIT];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			divCnt_q <= 16'h0000;
			clkOut_q <= 1'b0;
		end else if (!clkSrcSel) begin
			divCnt_q <= 16'h0000;
			clkOut_q <= 1'b0;
		end else if (divCnt_q == 16'(SER_DIV - 1)) begin
			divCnt_q <= 16'h0000;
			clkOut_q <= !clkOut_q;
		end else begin
			divCnt_q <= divCnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) extPrev_q <= 1'b0;
		else extPrev_q <= serClkIn;
	end

	assign tick = clkSrcSel ?
		(clkOut_q && divCnt_q == 16'(SER_DIV - 1)) :
		(extPrev_q && !serClkIn);
	// gated so the pin never shows a stale high once it turns input
	assign serClkOut = clkOut_q && clkSrcSel;
	assign serClkOeN = !clkSrcSel;

	// data changes on falling clock so the switch samples it stable
	// shift then latch
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sh_q <= SH_IDLE;
			sentWord_q <= '0;
			shWord_q <= '0;
			bitCnt_q <= 8'h00;
			serLatch <= 1'b0;
		end else if (tick) begin
			case (sh_q)
				SH_IDLE: begin
					if (cmdWord != sentWord_q) begin
						sentWord_q <= cmdWord;
						shWord_q <= cmdWord;
						bitCnt_q <= 8'h00;
						sh_q <= SH_SHIFT;
					end
				end
				SH_SHIFT: begin
					if (bitCnt_q == 8'(WORD_W - 1)) begin
						serLatch <= 1'b1;
						sh_q <= SH_LATCH;
					end else begin
						bitCnt_q <= bitCnt_q + 8'h01;
						shWord_q <= {shWord_q[WORD_W-2:0], 1'b0};
					end
				end
				SH_LATCH: begin
					serLatch <= 1'b0;
					sh_q <= SH_IDLE;
				end
				default: sh_q <= SH_IDLE;
			endcase
		end
	end

	assign serData = shWord_q[WORD_W-1];

	// --- zoomed video source selection ---

	// priority is taken from socket 0's function
	assign videoPrio = cardCtrl_q[0][VIDEO_PRIO_BIT];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			videoSource0SelectN <= 1'b1;
			videoSource1SelectN <= 1'b1;
			videoActiveStatus <= 1'b0;
		end else begin
			videoSource0SelectN <=
				!(videoEn[0] && (!videoEn[1] || !videoPrio));
			videoSource1SelectN <=
				!(videoEn[1] && (!videoEn[0] || videoPrio));
			videoActiveStatus <= |videoEn;
		end
	end

endmodule // card_detect_zv_select

// ---- hdl/card_socket_pkg.sv ----
// shared constants, types and register layout for the card socket logic
package card_socket_pkg;

	// configuration space layout
	localparam logic [7:0] SYS_CTRL_OFS = 8'h80;
	localparam logic [7:0] CARD_CTRL_OFS = 8'h91;
	localparam int SYS_CLK_SRC_BIT = 27;
	localparam int VIDEO_ENABLE_BIT = 6;
	localparam int VIDEO_PRIO_BIT = 5;
	localparam logic [31:0] SYS_CTRL_RST = 32'h00000000;
	localparam logic [7:0] CARD_CTRL_RST = 8'h00;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETTLE_TIME_NS = 1000;
	localparam int SETTLE_CYCLES =
		(SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SER_HALF_PERIOD_NS = 500;
	localparam int SER_DIV_HALF = SER_HALF_PERIOD_NS / CLK_PERIOD_NS;

	// sizes
	localparam int NUM_SOCKETS = 2;
	localparam int ADDR_W = 26;
	localparam int VIDEO_LOW_ADDR = 4;
	localparam int PS_WORD_W = 8;

	// supply codes sent to the power switch
	localparam logic [1:0] VCC_OFF = 2'h0;
	localparam logic [1:0] VCC_5V = 2'h1;
	localparam logic [1:0] VCC_3V3 = 2'h2;
	localparam logic [1:0] VCC_XV = 2'h3;
	localparam logic [1:0] VPP_OFF = 2'h0;

	typedef struct packed {
		logic cardDetectOne;
		logic cardDetectTwo;
		logic voltageSenseOne;
		logic voltageSenseTwo;
	} card_pins_t;

	typedef struct packed {
		logic valid;
		logic cardBus;
		logic v5;
		logic v33;
		logic vX;
		logic vY;
	} card_info_t;

	typedef enum logic [2:0] {
		IQ_IDLE,
		IQ_BASE,
		IQ_SENSE1,
		IQ_SENSE2,
		IQ_DONE
	} iq_state_t;

	typedef enum logic [1:0] {
		SH_IDLE,
		SH_SHIFT,
		SH_LATCH
	} sh_state_t;

endpackage

// ---- hdl/card_interrogate.sv ----
// per-socket card detect and voltage sense interrogation
`timescale 1ns/1ps
module card_interrogate #(
	parameter int SETTLE = card_socket_pkg::SETTLE_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// socket pins
	input wire card_socket_pkg::card_pins_t pins,
	input wire logic socketPowered,
	output logic [1:0] vsOeN,
	// result
	output card_socket_pkg::card_info_t info,
	output logic infoDone
);
	import card_socket_pkg::*;

	iq_state_t state_q;
	logic [15:0] settle_q;
	card_pins_t base_q;
	logic tie11_q, tie21_q;
	logic settled;

	function automatic card_info_t classify(card_pins_t b, logic t11,
		logic t21, logic t12, logic t22);
		card_info_t r;
		r = '0;
		if (!b.cardDetectOne && !b.cardDetectTwo) begin
			r.valid = 1'b1;
			case ({!b.voltageSenseTwo, !b.voltageSenseOne})
				2'b11: {r.v5, r.v33, r.vX} = 3'b111;
				2'b10: r.vX = 1'b1;
				2'b01: {r.v5, r.v33} = 2'b11;
				default: r.v5 = 1'b1;
			endcase
		end else if (!b.cardDetectTwo && t11) begin
			r.valid = b.voltageSenseTwo;
			r.cardBus = 1'b1;
			r.v33 = b.voltageSenseTwo;
		end else if (!b.cardDetectTwo && t12) begin
			r.valid = b.voltageSenseOne;
			r.cardBus = 1'b1;
			{r.vX, r.vY} = {2{b.voltageSenseOne}};
		end else if (!b.cardDetectOne && t22) begin
			r.valid = 1'b1;
			r.cardBus = 1'b1;
			r.v33 = !b.voltageSenseOne;
			r.vX = 1'b1;
		end else if (!b.cardDetectOne && t21) begin
			r.valid = 1'b1;
			r.cardBus = 1'b1;
			{r.v33, r.vX} = {2{!b.voltageSenseTwo}};
			r.vY = 1'b1;
		end
		return r;
	endfunction

	assign settled = (settle_q == 16'(SETTLE - 1));

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q <= IQ_IDLE;
			settle_q <= 16'h0000;
		end else begin
			settle_q <= settled ? 16'h0000 : settle_q + 16'h0001;
			case (state_q)
				IQ_IDLE: begin
					settle_q <= 16'h0000;
					if ((!pins.cardDetectOne || !pins.cardDetectTwo) &&
						!socketPowered) begin
						state_q <= IQ_BASE;
					end
				end
				IQ_BASE: if (settled) state_q <= IQ_SENSE1;
				IQ_SENSE1: if (settled) state_q <= IQ_SENSE2;
				IQ_SENSE2: if (settled) state_q <= IQ_DONE;
				IQ_DONE: begin
					settle_q <= 16'h0000;
					if (pins.cardDetectOne && pins.cardDetectTwo) begin
						state_q <= IQ_IDLE;
					end
				end
				default: state_q <= IQ_IDLE;
			endcase
		end
	end

	// drive a sense pin low to find which detect pin follows it
	assign vsOeN = {state_q != IQ_SENSE2, state_q != IQ_SENSE1};

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			base_q <= '1;
			tie11_q <= 1'b0;
			tie21_q <= 1'b0;
		end else if (settled) begin
			if (state_q == IQ_BASE) base_q <= pins;
			if (state_q == IQ_SENSE1) begin
				tie11_q <= base_q.cardDetectOne && !pins.cardDetectOne;
				tie21_q <= base_q.cardDetectTwo && !pins.cardDetectTwo;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			info <= '0;
			infoDone <= 1'b0;
		end else begin
			infoDone <= 1'b0;
			if (state_q == IQ_SENSE2 && settled) begin
				info <= classify(base_q, tie11_q, tie21_q,
					base_q.cardDetectOne && !pins.cardDetectOne,
					base_q.cardDetectTwo && !pins.cardDetectTwo);
				infoDone <= 1'b1;
			end else if (state_q == IQ_IDLE) begin
				info <= '0;
			end
		end
	end

endmodule // card_interrogate

// ---- bench/card_partner.sv ----
// card pins and power switch model for the socket bench
`timescale 1ns/1ps
module card_partner (
	// clock
	input logic clock,
	// socket side
	input logic [1:0][2:0] kind,
	input logic [1:0][1:0] vsOeN,
	output card_socket_pkg::card_pins_t [1:0] pins,
	// power switch side
	input logic serClk,
	input logic serData,
	input logic serLatch,
	output logic [7:0] word
);
	logic t1, t2, clkQ, latQ;
	logic [7:0] shiftQ;
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			t1 = vsOeN[s][0];
			t2 = vsOeN[s][1];
			// open lines pulled up, a tied pair follows the driven sense pin
			case (kind[s])
				3'h1: pins[s] = 4'h0;
				3'h2: pins[s] = 4'h2;
				3'h3: pins[s] = {1'b0, t1, t1, 1'b0};
				3'h4: pins[s] = {t2, 1'b0, 1'b1, t2};
				3'h5: pins[s] = {1'b0, t1, t1, 1'b1};
				3'h6: pins[s] = {t1, 1'b0, t1, 1'b0};
				default: pins[s] = 4'hF;
			endcase
			pins[s].voltageSenseOne &= t1;
			pins[s].voltageSenseTwo &= t2;
		end
	end
	always_ff @(posedge clock) begin
		clkQ <= serClk;
		latQ <= serLatch;
		if (serClk && !clkQ)
			shiftQ <= {shiftQ[6:0], serData};
		if (serLatch && !latQ)
			word <= shiftQ;
	end
endmodule // card_partner

// ---- bench/card_socket_checker.sv ----
// port assertions for the card socket logic
`timescale 1ns/1ps
module card_socket_checker (
	// clock and reset
	input logic clock,
	input logic rstn,
	// configuration access
	input logic cfgWr,
	input logic cfgRd,
	input logic cfgAck,
	// socket side
	input logic [1:0][1:0] vsOeN,
	input logic [1:0] infoDone,
	input logic [1:0][25:0] addrOeReqN,
	input logic [1:0][25:0] cardAddrOeN,
	// power switch link
	input logic serClkOut,
	input logic serClkOeN,
	input logic serLatch,
	// video selects
	input logic videoSource0SelectN,
	input logic videoSource1SelectN,
	input logic videoActiveStatus
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	ack_follows_req_a: assert property (cfgAck == $past(cfgWr || cfgRd))
		else $error("config ack out of step");
	clk_idle_low_a: assert property (serClkOeN |-> !serClkOut)
		else $error("serial clock driven while input");
	clk_runs_a: assert property (!serClkOeN |-> ##[1:120] $changed(serClkOut))
		else $error("serial clock stuck");
	latch_width_a: assert property (
		$rose(serLatch) |=> serLatch ##[1:200] !serLatch)
		else $error("latch pulse wrong");
	probe_one_pin_a: assert property (
		vsOeN[0] != 2'h0 && vsOeN[1] != 2'h0)
		else $error("both sense pins driven");
	done_pulse_a: assert property (infoDone[0] |=> !infoDone[0])
		else $error("done longer than one cycle");
	status_sel_a: assert property (
		videoActiveStatus == !(videoSource0SelectN && videoSource1SelectN))
		else $error("status disagrees with selects");
	one_source_a: assert property (
		videoSource0SelectN || videoSource1SelectN)
		else $error("both sources selected");
	addr_low_a: assert property ($past(rstn) |->
		{cardAddrOeN[1][3:0], cardAddrOeN[0][3:0]} ==
		$past({addrOeReqN[1][3:0], addrOeReqN[0][3:0]}))
		else $error("low address enables wrong");
	addr_idle_a: assert property ($past(rstn) && !videoActiveStatus |->
		cardAddrOeN == $past(addrOeReqN))
		else $error("address enables forced while idle");
	addr_float_a: assert property (
		(videoSource0SelectN || &cardAddrOeN[0][25:4]) &&
		(videoSource1SelectN || &cardAddrOeN[1][25:4]))
		else $error("upper address still driven");
endmodule // card_socket_checker
bind card_detect_zv_select card_socket_checker i_card_socket_checker (
	.clock, .rstn, .cfgWr, .cfgRd, .cfgAck, .vsOeN, .infoDone, .addrOeReqN,
	.cardAddrOeN, .serClkOut, .serClkOeN, .serLatch, .videoSource0SelectN,
	.videoSource1SelectN, .videoActiveStatus);

// ---- bench/testbench.sv ----
// self-checking bench for the card socket logic
`timescale 1ns/1ps
module testbench;
	import card_socket_pkg::*;
	logic clock = 0, rstn = 0, cfgFunc = 0, cfgWr = 0, cfgRd = 0;
	logic [7:0] cfgAddr = 0;
	logic [3:0] cfgByteEn = 0;
	logic [31:0] cfgWdata = 0, cfgRdata;
	logic cfgAck, serClkOut, serClkOeN, serData, serLatch, sawDone1 = 0;
	logic serClkIn = 0;
	logic videoSource0SelectN, videoSource1SelectN, videoActiveStatus;
	card_pins_t [1:0] cardPins;
	card_info_t [1:0] cardInfo;
	logic [1:0] socketPowered = 2'h2, infoDone;
	logic [1:0][1:0] vsOut, vsOeN;
	logic [1:0][25:0] addrOeReqN = {26'h2AAAAAA, 26'h1555555}, cardAddrOeN;
	logic [1:0][2:0] kind = 0;
	logic [7:0] word;
	int err_count = 0, checks_done = 0, cycles = 0;
	wire [2:0] videoPins = {videoSource0SelectN, videoSource1SelectN,
		videoActiveStatus};

	card_detect_zv_select #(.SETTLE(4), .SER_DIV(2)) i_card_detect_zv_select (
		.clock, .rstn, .cfgFunc, .cfgAddr, .cfgWr, .cfgRd, .cfgByteEn,
		.cfgWdata, .cfgRdata, .cfgAck, .cardPins, .socketPowered, .vsOut,
		.vsOeN, .cardInfo, .infoDone, .addrOeReqN, .cardAddrOeN,
		.serClkIn, .serClkOut, .serClkOeN, .serData, .serLatch,
		.videoSource0SelectN, .videoSource1SelectN, .videoActiveStatus);
	card_partner i_card_partner (.clock, .kind, .vsOeN, .pins(cardPins),
		.serClk(serClkOeN ? serClkIn : serClkOut), .serData,
		.serLatch, .word);

	always #5 clock = ~clock;

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic results;
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cfg(input logic wr, input logic fn, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(negedge clock);
		{cfgWr, cfgRd, cfgFunc, cfgAddr, cfgByteEn, cfgWdata} = {wr, !wr, fn,
			a, be, d};
		@(negedge clock);
		cfgWr = 0;
		cfgRd = 0;
		chk("cfgAck", 1, cfgAck);
	endtask

	task automatic t_reset;
		chk("clkOeN", 1, serClkOeN);
		chk("video", 3'h6, videoPins);
		chk("vsOut", 0, vsOut);
		cfg(0, 0, 8'h80, 4'hF, 0);
		chk("sysCtrl", SYS_CTRL_RST, cfgRdata);
		cfg(0, 1, 8'h91, 4'hF, 0);
		chk("cardCtrl", {16'h0, CARD_CTRL_RST, 8'h0}, cfgRdata);
		cfg(0, 0, 8'h44, 4'hF, 0);
		chk("unmapped", 0, cfgRdata);
	endtask

	task automatic t_cards;
		logic [5:0] expInfo [1:6] = '{6'h2E, 6'h22, 6'h37, 6'h33, 6'h31, 6'h0};
		logic [5:0] msk;
		int n;
		// socket 1 is powered, so its card must never be probed
		kind[1] = 3'h1;
		for (int k = 1; k <= 6; k++) begin
			msk = (k == 6) ? 6'h20 : 6'h3F;
			kind[0] = 3'(k);
			n = 0;
			while (infoDone[0] !== 1'b1 && n < 60) begin
				@(negedge clock);
				n++;
			end
			chk("info", expInfo[k] & msk, cardInfo[0] & msk);
			kind[0] = 0;
			repeat (6) @(negedge clock);
			chk("removed", 0, cardInfo[0]);
		end
		chk("powered", 0, sawDone1);
	endtask

	task automatic t_serial;
		int n;
		kind[0] = 3'h1;
		repeat (20) @(negedge clock);
		// external clock: twelve slow periods, left low afterwards
		repeat (24) begin
			repeat (2) @(negedge clock);
			serClkIn = !serClkIn;
		end
		repeat (4) @(negedge clock);
		chk("extSwitch", 8'h08, word);
		// swap to a low-voltage-only card, then run the internal clock
		kind[0] = 0;
		repeat (4) @(negedge clock);
		kind[0] = 3'h2;
		repeat (20) @(negedge clock);
		cfg(1, 0, 8'h80, 4'hF, 32'h08000000);
		@(negedge clock);
		chk("clkOeN", 0, serClkOeN);
		n = 0;
		while (word !== 8'h0C && n < 400) begin
			@(negedge clock);
			n++;
		end
		chk("switch", 8'h0C, word);
		cfg(0, 0, 8'h80, 4'hF, 0);
		chk("sysCtrl", 32'h08000000, cfgRdata);
	endtask

	task automatic t_video;
		logic e0, e1, p, s0, s1;
		for (int i = 0; i < 8; i++) begin
			{p, e1, e0} = 3'(i);
			cfg(1, 0, 8'h91, 4'h2, {16'h0, 1'b0, e0, p, 5'h0, 8'h0});
			cfg(1, 1, 8'h91, 4'h2, {16'h0, 1'b0, e1, 6'h0, 8'h0});
			repeat (2) @(negedge clock);
			s1 = e1 && (p || !e0);
			s0 = e0 && !s1;
			chk("video", {!s0, !s1, s0 | s1}, videoPins);
			chk("addr0", addrOeReqN[0] | {{22{e0}}, 4'h0}, cardAddrOeN[0]);
			chk("addr1", addrOeReqN[1] | {{22{e1}}, 4'h0}, cardAddrOeN[1]);
		end
		// lane 1 disabled must leave the control byte alone
		cfg(1, 0, 8'h91, 4'h1, 0);
		cfg(0, 0, 8'h91, 4'hF, 0);
		chk("cardCtrl", 32'h6000, cfgRdata);
	endtask

	initial begin
		repeat (2) @(posedge clock);
		@(negedge clock);
		rstn = 1;
		t_reset();
		t_cards();
		t_serial();
		t_video();
		results();
	end

	always @(posedge clock) begin
		cycles++;
		if (infoDone[1] === 1'b1)
			sawDone1 = 1;
		if (cycles == 5000) begin
			err_count++;
			results();
		end
	end
endmodule // testbench
